/* dmem_cfg.svh */
// offsets, field positions, reset values and timing counts of the decoder
`ifndef DMEM_CFG_SVH
`define DMEM_CFG_SVH

// ----------------------------------------------------------------
// special-function register offsets and reset values
// ----------------------------------------------------------------
`define PAGE_PTR_ADDR    8'h85
`define BANK_CTRL_ADDR   8'h86
`define SYS_CFG_ADDR     8'hbf
`define PAGE_PTR_RST     8'h00
`define BANK_CTRL_RST    8'h00
`define SYS_CFG_RST      8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BANK_EN_BIT      7
`define BANK_SEL_MSB     3
`define BANK_USED_MASK   8'h8f
`define XRAM_EN_BIT      0
`define FLASH_EN_BIT     3

// ----------------------------------------------------------------
// address map
// ----------------------------------------------------------------
`define XRAM_TOP         16'h02ff
`define DIRECT_TOP       8'h7f
`define BANKS_TOP        8'h1f
`define BITS_TOP         8'h2f
`define WINDOW_TAG       2'b01
`define XRAM_BASE        10'h100

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS    25
`define EXT_STROBE_NS    100
`define EXT_STROBE_CYC   ((`EXT_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_STAGES      2

`endif

/* dmem_pkg.sv */
// types shared by the data memory decoder modules
package dmem_pkg;

   typedef enum logic [1:0] {
      KIND_DIRECT,
      KIND_INDIRECT,
      KIND_EXT_PTR,
      KIND_EXT_PAGE
   } kind_e;

   typedef enum logic [1:0] {
      TGT_RAM,
      TGT_FLASH,
      TGT_EXT,
      TGT_NONE
   } target_e;

   typedef enum logic [2:0] {
      REG_BANKS,
      REG_BITS,
      REG_BYTES,
      REG_UPPER,
      REG_XRAM,
      REG_OUTSIDE
   } region_e;

   typedef struct packed {
      target_e     target;
      logic [9:0]  ram_addr;
      logic [15:0] ext_addr;
      region_e     region;
      logic        refused;
   } route_s;

endpackage

/* ram_port_if.sv */
// port of the 1KB on-chip ram store
`timescale 1ns/1ps
interface ram_port_if;
   logic       en;
   logic       we;
   logic [9:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport owner (output en, we, addr, wdata, input rdata);
   modport store (input en, we, addr, wdata, output rdata);
endinterface

/* ram_store.sv */
// 1KB of ram in flip-flops: internal 000h-0ffh, expanded 100h-3ffh
`timescale 1ns/1ps
module ram_store
(
   input  wire logic  sys_clk_i,
   input  wire logic  reset_i,
   ram_port_if.store  port
);
   logic [7:0] mem [0:1023];

   // ----------------------------------------------------------------
   // storage
   // ----------------------------------------------------------------
   for (genvar i = 0; i < 1024; i++)
   begin : g_byte
      always_ff @(posedge sys_clk_i)
      begin
         if (port.en && port.we && port.addr == 10'(i))
            mem[i] <= port.wdata;
      end
   end

   // read data holds until the next enabled read
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
         port.rdata <= 8'h00;
      else if (port.en && !port.we)
         port.rdata <= mem[port.addr];
   end
endmodule // ram_store

/* addr_steer.sv */
// steers one data access to ram, data flash, off-chip bus or refusal
`timescale 1ns/1ps
`include "dmem_cfg.svh"
module addr_steer
(
   input  wire dmem_pkg::kind_e  kind_i,
   input  wire logic             write_i,
   input  wire logic [15:0]      addr_i,
   input  wire logic [7:0]       page_i,
   input  wire logic [7:0]       bank_ctrl_i,
   input  wire logic [7:0]       sys_cfg_i,
   output dmem_pkg::route_s      route_o
);
   logic [15:0] ext_a;
   logic        low;

   function automatic dmem_pkg::region_e region_of(input logic [7:0] a);
      if (a <= `BANKS_TOP)
         return dmem_pkg::REG_BANKS;
      else if (a <= `BITS_TOP)
         return dmem_pkg::REG_BITS;
      else if (a <= `DIRECT_TOP)
         return dmem_pkg::REG_BYTES;
      else
         return dmem_pkg::REG_UPPER;
   endfunction

   always_comb
   begin
      ext_a = (kind_i == dmem_pkg::KIND_EXT_PAGE) ?
              {page_i, addr_i[7:0]} : addr_i;
      low   = ext_a <= `XRAM_TOP;
      route_o = '{target: dmem_pkg::TGT_NONE, ram_addr: 10'h000,
                  ext_addr: 16'h0000, region: dmem_pkg::REG_OUTSIDE,
                  refused: 1'b0};
      unique case (kind_i)
         dmem_pkg::KIND_DIRECT:
         begin
            if (addr_i[15:8] != 8'h00 || addr_i[7:0] > `DIRECT_TOP)
               route_o.refused = 1'b1;
            else
            begin
               route_o.target = dmem_pkg::TGT_RAM;
               route_o.region = region_of(addr_i[7:0]);
               if (bank_ctrl_i[`BANK_EN_BIT] &&
                   addr_i[7:6] == `WINDOW_TAG)
                  route_o.ram_addr = {bank_ctrl_i[`BANK_SEL_MSB:0],
                                      addr_i[5:0]};
               else
                  route_o.ram_addr = {2'b00, addr_i[7:0]};
            end
         end
         dmem_pkg::KIND_INDIRECT:
         begin
            if (addr_i[15:8] != 8'h00)
               route_o.refused = 1'b1;
            else
            begin
               route_o.target   = dmem_pkg::TGT_RAM;
               route_o.region   = region_of(addr_i[7:0]);
               route_o.ram_addr = {2'b00, addr_i[7:0]};
            end
         end
         dmem_pkg::KIND_EXT_PTR, dmem_pkg::KIND_EXT_PAGE:
         begin
            route_o.ext_addr = ext_a;
            route_o.region   = low ? dmem_pkg::REG_XRAM
                                   : dmem_pkg::REG_OUTSIDE;
            if (kind_i == dmem_pkg::KIND_EXT_PAGE && write_i)
               route_o.refused = 1'b1;
            else if (low && sys_cfg_i[`XRAM_EN_BIT])
            begin
               route_o.target   = dmem_pkg::TGT_RAM;
               route_o.ram_addr = `XRAM_BASE + ext_a[9:0];
            end
            else if (sys_cfg_i[`FLASH_EN_BIT])
               route_o.target = dmem_pkg::TGT_FLASH;
            else
               route_o.target = dmem_pkg::TGT_EXT;
         end
      endcase
   end
endmodule // addr_steer

/* data_memory_map_decoder.sv */
// data memory decoder: sfr registers, access sequencing, ram and buses
`timescale 1ns/1ps
`include "dmem_cfg.svh"
module data_memory_map_decoder
(
   input  wire logic         sys_clk_i,
   input  wire logic         reset_i,
   input  wire logic         sfr_wr_i,
   input  wire logic         sfr_rd_i,
   input  wire logic [7:0]   sfr_addr_i,
   input  wire logic [7:0]   sfr_wdata_i,
   output logic [7:0]        sfr_rdata_o,
   output logic              sfr_ack_o,
   input  wire logic         req_valid_i,
   input  wire logic [1:0]   req_kind_i,
   input  wire logic         req_write_i,
   input  wire logic [15:0]  req_addr_i,
   input  wire logic [7:0]   req_wdata_i,
   output logic              req_ready_o,
   output logic              rsp_valid_o,
   output logic [7:0]        rsp_rdata_o,
   output logic              rsp_refused_o,
   output logic [2:0]        rsp_region_o,
   output logic              flash_rd_o,
   output logic [15:0]       flash_addr_o,
   input  wire logic [7:0]   flash_rdata_i,
   output logic              ext_rd_o,
   output logic              ext_wr_o,
   output logic [15:0]       ext_addr_o,
   output logic [7:0]        ext_data_o,
   output logic              ext_data_oe_o,
   input  wire logic [7:0]   ext_data_i
);
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_FLASH_WAIT,
      ST_EXT_STROBE,
      ST_EXT_SETTLE,
      ST_LOCAL
   } state_e;

   state_e                state_reg;
   logic [2:0]            cnt_reg;
   logic                  write_reg;
   dmem_pkg::target_e     tgt_reg;
   dmem_pkg::region_e     region_reg;
   logic [7:0]            page_reg;
   logic [7:0]            bank_reg;
   logic [7:0]            sys_reg;
   logic [7:0]            sync1_reg;
   logic [7:0]            sync2_reg;
   logic                  accept;
   dmem_pkg::route_s      route;

   ram_port_if ram ();

   assign accept = req_valid_i && req_ready_o;
   assign rsp_region_o = region_reg;

   addr_steer u_steer
   (
      .kind_i      (dmem_pkg::kind_e'(req_kind_i)),
      .write_i     (req_write_i),
      .addr_i      (req_addr_i),
      .page_i      (page_reg),
      .bank_ctrl_i (bank_reg),
      .sys_cfg_i   (sys_reg),
      .route_o     (route)
   );

   ram_store u_ram
   (
      .sys_clk_i (sys_clk_i),
      .reset_i   (reset_i),
      .port      (ram.store)
   );

   // ----------------------------------------------------------------
   // special-function registers
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         page_reg <= `PAGE_PTR_RST;
         bank_reg <= `BANK_CTRL_RST;
         sys_reg  <= `SYS_CFG_RST;
      end
      else if (sfr_wr_i)
      begin
         if (sfr_addr_i == `PAGE_PTR_ADDR)
            page_reg <= sfr_wdata_i;
         if (sfr_addr_i == `BANK_CTRL_ADDR)
            bank_reg <= sfr_wdata_i & `BANK_USED_MASK;
         if (sfr_addr_i == `SYS_CFG_ADDR)
            sys_reg <= sfr_wdata_i;
      end
   end

   // unmapped offsets give no ack so the core's own sfr decode answers
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sfr_ack_o   <= 1'b0;
         sfr_rdata_o <= 8'h00;
      end
      else
      begin
         sfr_ack_o <= (sfr_rd_i || sfr_wr_i) &&
                      (sfr_addr_i == `PAGE_PTR_ADDR ||
                       sfr_addr_i == `BANK_CTRL_ADDR ||
                       sfr_addr_i == `SYS_CFG_ADDR);
         if (sfr_rd_i)
         begin
            unique case (sfr_addr_i)
               `PAGE_PTR_ADDR:  sfr_rdata_o <= page_reg;
               `BANK_CTRL_ADDR: sfr_rdata_o <= bank_reg;
               `SYS_CFG_ADDR:   sfr_rdata_o <= sys_reg;
               default:         sfr_rdata_o <= 8'h00;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // ram port: driven in the accept cycle, so ram reads cost one edge
   // ----------------------------------------------------------------
   always_comb
   begin
      ram.en    = accept && route.target == dmem_pkg::TGT_RAM;
      ram.we    = req_write_i;
      ram.addr  = route.ram_addr;
      ram.wdata = req_wdata_i;
   end

   // ----------------------------------------------------------------
   // access sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         state_reg     <= ST_IDLE;
         req_ready_o   <= 1'b1;
         rsp_valid_o   <= 1'b0;
         rsp_rdata_o   <= 8'h00;
         rsp_refused_o <= 1'b0;
         region_reg    <= dmem_pkg::REG_OUTSIDE;
         tgt_reg       <= dmem_pkg::TGT_NONE;
         write_reg     <= 1'b0;
         cnt_reg       <= 3'd0;
      end
      else
      begin
         rsp_valid_o <= 1'b0;
         unique case (state_reg)
            ST_IDLE:
            begin
               if (accept)
               begin
                  req_ready_o   <= 1'b0;
                  tgt_reg       <= route.target;
                  rsp_refused_o <= route.refused;
                  region_reg    <= route.region;
                  write_reg     <= req_write_i;
                  if (route.target == dmem_pkg::TGT_EXT)
                  begin
                     state_reg <= ST_EXT_STROBE;
                     cnt_reg   <= 3'(`EXT_STROBE_CYC - 1);
                  end
                  else if (route.target == dmem_pkg::TGT_FLASH &&
                           !req_write_i)
                     state_reg <= ST_FLASH_WAIT;
                  else
                     state_reg <= ST_LOCAL;
               end
            end
            ST_FLASH_WAIT:
               state_reg <= ST_LOCAL;
            ST_EXT_STROBE:
            begin
               if (cnt_reg == 3'd0)
               begin
                  state_reg <= ST_EXT_SETTLE;
                  cnt_reg   <= 3'(`SYNC_STAGES - 1);
               end
               else
                  cnt_reg <= cnt_reg - 3'd1;
            end
            ST_EXT_SETTLE:
            begin
               if (cnt_reg == 3'd0)
               begin
                  state_reg   <= ST_IDLE;
                  req_ready_o <= 1'b1;
                  rsp_valid_o <= 1'b1;
                  rsp_rdata_o <= write_reg ? 8'h00 : sync2_reg;
               end
               else
                  cnt_reg <= cnt_reg - 3'd1;
            end
            ST_LOCAL:
            begin
               state_reg   <= ST_IDLE;
               req_ready_o <= 1'b1;
               rsp_valid_o <= 1'b1;
               if (write_reg || tgt_reg == dmem_pkg::TGT_NONE)
                  rsp_rdata_o <= 8'h00;
               else if (tgt_reg == dmem_pkg::TGT_FLASH)
                  rsp_rdata_o <= flash_rdata_i;
               else
                  rsp_rdata_o <= ram.rdata;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // data flash read strobe; no write path exists toward the flash
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         flash_rd_o   <= 1'b0;
         flash_addr_o <= 16'h0000;
      end
      else if (accept && route.target == dmem_pkg::TGT_FLASH &&
               !req_write_i)
      begin
         flash_rd_o   <= 1'b1;
         flash_addr_o <= route.ext_addr;
      end
      else
         flash_rd_o <= 1'b0;
   end

   // ----------------------------------------------------------------
   // off-chip bus: fixed-length strobe, read data through two flops
   // ----------------------------------------------------------------
   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ext_rd_o      <= 1'b0;
         ext_wr_o      <= 1'b0;
         ext_data_oe_o <= 1'b0;
         ext_addr_o    <= 16'h0000;
         ext_data_o    <= 8'h00;
      end
      else if (accept && route.target == dmem_pkg::TGT_EXT)
      begin
         ext_rd_o      <= !req_write_i;
         ext_wr_o      <= req_write_i;
         ext_data_oe_o <= req_write_i;
         ext_addr_o    <= route.ext_addr;
         ext_data_o    <= req_wdata_i;
      end
      else if (state_reg == ST_EXT_STROBE && cnt_reg == 3'd0)
      begin
         ext_rd_o      <= 1'b0;
         ext_wr_o      <= 1'b0;
         ext_data_oe_o <= 1'b0;
      end
   end

   always_ff @(posedge sys_clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= ext_data_i;
         sync2_reg <= sync1_reg;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);

   reset_values_a: assert property ($past(reset_i) |->
      page_reg == 8'h00 && bank_reg == 8'h00 && sys_reg == 8'h00)
      else $error("config registers not cleared by reset");
   bank_unused_a: assert property (sfr_rd_i &&
      sfr_addr_i == `BANK_CTRL_ADDR |=> sfr_rdata_o[6:4] == 3'b000)
      else $error("unused window control bits read non-zero");
   ram_rsp_a: assert property (accept &&
      route.target == dmem_pkg::TGT_RAM |-> ##2 rsp_valid_o &&
      !rsp_refused_o)
      else $error("ram access not answered two cycles later");
   flash_read_a: assert property (accept && !req_write_i &&
      route.target == dmem_pkg::TGT_FLASH |=> flash_rd_o ##2 rsp_valid_o
      && rsp_rdata_o == $past(flash_rdata_i))
      else $error("flash read not strobed or answered");
   ext_route_a: assert property (accept && req_kind_i[1] &&
      !route.refused && !sys_reg[`FLASH_EN_BIT] &&
      route.ext_addr > `XRAM_TOP |=> (ext_rd_o || ext_wr_o))
      else $error("external move above 2ffh did not go off-chip");
   ext_strobe_a: assert property (accept && !req_write_i &&
      route.target == dmem_pkg::TGT_EXT |=> ext_rd_o [*4] ##1 !ext_rd_o
      ##2 rsp_valid_o)
      else $error("off-chip read strobe has wrong length");
   ext_write_a: assert property (accept && req_write_i &&
      route.target == dmem_pkg::TGT_EXT |=> ext_data_o ==
      $past(req_wdata_i) ##0 (ext_wr_o && ext_data_oe_o) [*4] ##1
      (!ext_wr_o && !ext_data_oe_o))
      else $error("off-chip write strobe or data wrong");
   xram_map_a: assert property (accept && req_kind_i[1] &&
      sys_reg[`XRAM_EN_BIT] && route.ext_addr <= `XRAM_TOP && !route.refused
      |-> ram.en && ram.addr == `XRAM_BASE + route.ext_addr[9:0])
      else $error("expanded ram address mapped wrongly");
   page_addr_a: assert property (accept && !req_write_i &&
      req_kind_i == 2'b11 && route.target == dmem_pkg::TGT_EXT |=>
      ext_addr_o == {$past(page_reg), $past(req_addr_i[7:0])})
      else $error("paged read address not page and index");
   page_write_a: assert property (accept && req_write_i &&
      req_kind_i == 2'b11 |-> ##2 rsp_valid_o && rsp_refused_o)
      else $error("paged write was not refused");
   window_a: assert property (accept && req_kind_i == 2'b00 &&
      bank_reg[`BANK_EN_BIT] && req_addr_i[15:6] == 10'h001 |->
      ram.en && ram.addr == 10'(req_addr_i[5:0]) +
      (bank_reg[3:2] == 2'b00 ? 10'(bank_reg[1:0]) * 10'h040 :
      `XRAM_BASE + 10'(bank_reg[3:0] - 4'h4) * 10'h040))
      else $error("window remap reached the wrong base");
   window_off_a: assert property (accept &&
      req_kind_i[1] == 1'b0 && !bank_reg[`BANK_EN_BIT] &&
      req_addr_i <= 16'h007f |-> ram.en && ram.addr == req_addr_i[9:0])
      else $error("unmapped access did not reach lower ram");
   region_a: assert property (accept && req_kind_i == 2'b00 &&
      req_addr_i <= 16'h007f |=> rsp_region_o == (($past(req_addr_i) <=
      16'h001f) ? 3'd0 : ($past(req_addr_i) <= 16'h002f) ? 3'd1 : 3'd2))
      else $error("direct region class wrong");
   upper_ind_a: assert property (accept && req_kind_i == 2'b01 &&
      req_addr_i[15:7] == 9'h001 |-> ram.en)
      else $error("upper bytes not reachable indirectly");
   flash_write_a: assert property (accept && req_write_i &&
      route.target == dmem_pkg::TGT_FLASH |=> !flash_rd_o && !ext_wr_o
      ##1 rsp_valid_o)
      else $error("flash write had an effect");

   ram_cov: cover property (accept && route.target == dmem_pkg::TGT_RAM);
   flash_cov: cover property (accept && route.target == dmem_pkg::TGT_FLASH);
   ext_cov: cover property (accept && ext_wr_o == 1'b0 &&
      route.target == dmem_pkg::TGT_EXT);
   window_cov: cover property (accept && bank_reg[`BANK_EN_BIT]);
endmodule // data_memory_map_decoder

/* far_memory.sv */
// far-side model: data flash array and off-chip memory
`timescale 1ns/1ps
module far_memory
(
   input  wire logic        sys_clk_i,
   input  wire logic        flash_rd_i,
   input  wire logic [15:0] flash_addr_i,
   output logic [7:0]       flash_rdata_o,
   input  wire logic        ext_rd_i,
   input  wire logic [15:0] ext_addr_i,
   output logic [7:0]       ext_data_o
);
   logic [7:0] ext_last;

   initial flash_rdata_o = 8'h00;
   initial ext_last = 8'h00;

   // flash holds a fixed pattern: nothing here can ever alter it
   always @(posedge sys_clk_i)
   begin
      if (flash_rd_i)
         flash_rdata_o <= flash_addr_i[7:0] ^ flash_addr_i[15:8];
      else
         flash_rdata_o <= ~flash_rdata_o;  // stale data must not linger
      if (ext_rd_i)
         ext_last <= ext_addr_i[7:0] ^ ext_addr_i[15:8] ^ 8'ha5;
   end

   // released bus shows the inverse of the last value, not a held copy
   assign ext_data_o = ext_rd_i ? (ext_addr_i[7:0] ^ ext_addr_i[15:8] ^ 8'ha5)
                                : ~ext_last;
endmodule // far_memory

/* testbench.sv */
// self-checking bench for the data memory decoder
`timescale 1ns/1ps
module testbench;
   logic sys_clk_i = 1'b0, reset_i = 1'b1, sfr_wr, sfr_rd, valid, wr;
   logic [7:0]  sfr_addr, sfr_wdata, wdata, sfr_rdata, rdata, fl_d, ex_d;
   logic [7:0]  ex_o;
   logic [15:0] addr, fl_a, ex_a;
   logic [1:0]  kind;
   logic [2:0]  region;
   logic ack, ready, rsp, refused, fl_rd, ex_rd, ex_wr, ex_oe;
   int bad_count = 0, checks = 0;

   always #12.5 sys_clk_i = ~sys_clk_i;

   data_memory_map_decoder u_dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i),
      .sfr_wr_i(sfr_wr), .sfr_rd_i(sfr_rd), .sfr_addr_i(sfr_addr),
      .sfr_wdata_i(sfr_wdata), .sfr_rdata_o(sfr_rdata), .sfr_ack_o(ack),
      .req_valid_i(valid), .req_kind_i(kind), .req_write_i(wr),
      .req_addr_i(addr), .req_wdata_i(wdata), .req_ready_o(ready),
      .rsp_valid_o(rsp), .rsp_rdata_o(rdata), .rsp_refused_o(refused),
      .rsp_region_o(region), .flash_rd_o(fl_rd), .flash_addr_o(fl_a),
      .flash_rdata_i(fl_d), .ext_rd_o(ex_rd), .ext_wr_o(ex_wr),
      .ext_addr_o(ex_a), .ext_data_o(ex_o), .ext_data_oe_o(ex_oe),
      .ext_data_i(ex_d));

   far_memory u_far (.sys_clk_i(sys_clk_i), .flash_rd_i(fl_rd),
      .flash_addr_i(fl_a), .flash_rdata_o(fl_d), .ext_rd_i(ex_rd),
      .ext_addr_i(ex_a), .ext_data_o(ex_d));

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
   begin
      checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   end
   endtask

   task automatic summarize;
   begin
      $display("checks=%0d bad_count=%0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   end
   endtask

   task automatic sfr(input logic w, input logic [7:0] a, input logic [7:0] d,
                      input logic [7:0] exp, input logic exp_ack);
   begin
      @(posedge sys_clk_i);
      #1 sfr_wr = w; sfr_rd = ~w; sfr_addr = a; sfr_wdata = d;
      @(posedge sys_clk_i);
      #1 sfr_wr = 1'b0; sfr_rd = 1'b0;
      check({15'h0000, ack}, {15'h0000, exp_ack});
      if (!w) check({8'h00, sfr_rdata}, {8'h00, exp});
   end
   endtask

   // region 7 means the region is not judged
   task automatic acc(input logic [1:0] k, input logic w, input logic [15:0] a,
      input logic [7:0] d, input logic [7:0] exp, input logic exp_ref,
      input logic [2:0] exp_reg);
      int n;
   begin
      @(posedge sys_clk_i);
      #1 valid = 1'b1; kind = k; wr = w; addr = a; wdata = d;
      @(posedge sys_clk_i);
      #1 valid = 1'b0;
      for (n = 0; n < 20 && rsp !== 1'b1; n++)
         @(posedge sys_clk_i) #1;
      if (n == 20)
      begin
         bad_count++;
         summarize();
      end
      else
      begin
         check({8'h00, rdata}, {8'h00, w | exp_ref ? 8'h00 : exp});
         check({15'h0000, refused}, {15'h0000, exp_ref});
         if (exp_reg != 3'h7)
            check({13'h0000, region}, {13'h0000, exp_reg});
      end
   end
   endtask

   task automatic reset_values;
   begin
      sfr(1'b0, 8'h85, 8'h00, 8'h00, 1'b1);
      sfr(1'b0, 8'h86, 8'h00, 8'h00, 1'b1);
      sfr(1'b0, 8'hbf, 8'h00, 8'h00, 1'b1);
      sfr(1'b0, 8'h84, 8'h00, 8'h00, 1'b0);
      acc(2'd2, 1'b0, 16'h0100, 0, 8'ha4, 1'b0, 3'h7);
   end
   endtask

   task automatic lower_ram;
   begin
      acc(2'd0, 1'b1, 16'h0043, 8'h3c, 0, 1'b0, 3'h2);
      acc(2'd1, 1'b0, 16'h0043, 0, 8'h3c, 1'b0, 3'h2);
      acc(2'd0, 1'b1, 16'h0010, 8'h5a, 0, 1'b0, 3'h0);
      acc(2'd1, 1'b1, 16'h0025, 8'h25, 0, 1'b0, 3'h1);
      acc(2'd1, 1'b1, 16'h0085, 8'haa, 0, 1'b0, 3'h3);
      acc(2'd0, 1'b0, 16'h0085, 0, 0, 1'b1, 3'h7);
   end
   endtask

   task automatic window_map;
   begin
      sfr(1'b1, 8'h86, 8'hff, 0, 1'b1);
      sfr(1'b0, 8'h86, 0, 8'h8f, 1'b1);
      sfr(1'b1, 8'h86, 8'h82, 0, 1'b1);
      acc(2'd0, 1'b0, 16'h0045, 0, 8'haa, 1'b0, 3'h7);
      sfr(1'b1, 8'hbf, 8'h01, 0, 1'b1);
      acc(2'd2, 1'b1, 16'h0203, 8'h55, 0, 1'b0, 3'h7);
      sfr(1'b1, 8'h86, 8'h8c, 0, 1'b1);
      acc(2'd0, 1'b0, 16'h0043, 0, 8'h55, 1'b0, 3'h7);
      sfr(1'b1, 8'h86, 8'h0c, 0, 1'b1);
      acc(2'd0, 1'b0, 16'h0043, 0, 8'h3c, 1'b0, 3'h7);
      acc(2'd2, 1'b0, 16'h0400, 0, 8'ha1, 1'b0, 3'h7);
      acc(2'd2, 1'b1, 16'h0500, 8'h3e, 0, 1'b0, 3'h5);
      check(ex_a, 16'h0500);
      check({8'h00, ex_o}, {8'h00, 8'h3e});
   end
   endtask

   task automatic flash_map;
   begin
      sfr(1'b1, 8'hbf, 8'h09, 0, 1'b1);
      acc(2'd2, 1'b0, 16'h1234, 0, 8'h26, 1'b0, 3'h7);
      acc(2'd2, 1'b0, 16'h0203, 0, 8'h55, 1'b0, 3'h7);
      acc(2'd2, 1'b1, 16'h0400, 8'h77, 0, 1'b0, 3'h7);
      acc(2'd2, 1'b0, 16'h0400, 0, 8'h04, 1'b0, 3'h7);
      sfr(1'b1, 8'hbf, 8'h08, 0, 1'b1);
      acc(2'd2, 1'b0, 16'h0100, 0, 8'h01, 1'b0, 3'h7);
      sfr(1'b1, 8'h85, 8'h12, 0, 1'b1);
      acc(2'd3, 1'b0, 16'h0034, 0, 8'h26, 1'b0, 3'h7);
      acc(2'd3, 1'b1, 16'h0034, 8'h11, 0, 1'b1, 3'h7);
      sfr(1'b1, 8'hbf, 8'h00, 0, 1'b1);
      acc(2'd3, 1'b0, 16'h0034, 0, 8'h83, 1'b0, 3'h5);
      check(ex_a, 16'h1234);
   end
   endtask

   initial
   begin
      {sfr_wr, sfr_rd, valid, wr, kind} = '0;
      {sfr_addr, sfr_wdata, addr, wdata} = '0;
      repeat (6) @(posedge sys_clk_i);
      #1 reset_i = 1'b0;
      reset_values();
      lower_ram();
      window_map();
      flash_map();
      summarize();
   end
endmodule // testbench
